/* File: rtl/rcsc_cfg.svh */
/*
 * Constants of the reset cause and start-up control block: register offsets,
 * field positions, reset values and the start-up delay count.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef RCSC_CFG_SVH
`define RCSC_CFG_SVH

// start-up delay, in system clock pulses
`define RCSC_STARTUP_CYCLES     1024

// Avalon-MM register map (byte addresses, one 32-bit word each)
`define RCSC_ADDR_W             4
`define RCSC_OFS_CAUSE          4'h0
`define RCSC_OFS_IRQ_STATUS     4'h4
`define RCSC_OFS_IRQ_MASK       4'h8

// cause register fields
`define RCSC_CAUSE_POWERDOWN    0
`define RCSC_CAUSE_TIMEOUT      1
`define RCSC_CAUSE_STATE_LO     2
`define RCSC_CAUSE_POWERUP      8

// interrupt status and mask bits
`define RCSC_IRQ_W              3
`define RCSC_IRQ_CHIP_DONE      0
`define RCSC_IRQ_WARM           1
`define RCSC_IRQ_WAKE           2
`define RCSC_IRQ_MASK_RST       3'h0

// reset values loaded into the functional units on a chip reset
`define RCSC_TIMER_CONTROL_RST  8'h08
`define RCSC_INT_CONTROL_RST    8'h00
`define RCSC_CONV_CONTROL_RST   8'h40
`define RCSC_PORTA_RST          8'hff
`define RCSC_PORTB_RST          4'hf
`define RCSC_PORTD_RST          1'h1

`endif

/* File: rtl/rcsc_pkg.sv */
/*
 * Types of the reset cause and start-up control block.
 * Assumes rcsc_cfg.svh is on the include path.
 */
`include "rcsc_cfg.svh"

package rcsc_pkg;

    typedef enum logic [2:0] {
        RCSC_ST_RUN        = 3'b000,
        RCSC_ST_SLEEP      = 3'b001,
        RCSC_ST_PIN_HOLD   = 3'b010,
        RCSC_ST_RST_DELAY  = 3'b011,
        RCSC_ST_WAKE_DELAY = 3'b100
    } rcsc_state_t;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } rcsc_flags_t;

    typedef struct packed {
        logic halt_exec;
        logic watchdog_clear_exec;
        logic wake_event;
        logic watchdog_timeout;
    } rcsc_core_evt_t;

    typedef struct packed {
        logic chip_reset;
        logic stall;
        logic pc_sp_clear;
        logic watchdog_clear;
        logic load_defaults;
        logic powerup;
    } rcsc_core_ctl_t;

    typedef struct packed {
        logic [7:0] timer_control;
        logic [7:0] interrupt_control;
        logic [7:0] converter_control;
        logic [7:0] porta_data;
        logic [7:0] porta_dir;
        logic [3:0] portb_data;
        logic [3:0] portb_dir;
        logic       portd_data;
        logic       portd_dir;
    } rcsc_defaults_t;

endpackage

/* File: rtl/rcsc_startup_timer.sv */
/*
 * Start-up delay counter: counts a fixed number of system clock pulses
 * after each start, and runs one delay out of reset.
 * Assumes i_start comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rcsc_cfg.svh"

module rcsc_startup_timer #(
    parameter int unsigned CYCLES = `RCSC_STARTUP_CYCLES
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_ce,
    // control
    input  wire logic i_start,
    // status
    output logic      o_busy,
    output logic      o_last
);
    import rcsc_pkg::*;

    localparam int unsigned    CW   = $clog2(CYCLES + 1);
    localparam logic [CW-1:0]  LOAD = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          busy;
    } rcsc_tmr_state_t;

    rcsc_tmr_state_t state;
    rcsc_tmr_state_t next_state;

    always_comb begin
        next_state = state;
        if (i_start) begin
            next_state.count = LOAD;
            next_state.busy  = 1'b1;
        end else if (state.busy) begin
            if (state.count == '0) begin
                next_state.busy = 1'b0;
            end else begin
                next_state.count = state.count - 1'b1;
            end
        end
    end

    // a power-up runs a full delay straight out of reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state.count <= LOAD;
            state.busy  <= 1'b1;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    assign o_busy = state.busy;
    assign o_last = state.busy && (state.count == '0) && !i_start;

endmodule

`default_nettype wire

/* File: rtl/rcsc_top.sv */
/*
 * Reset cause and start-up control: sequences chip resets and warm resets,
 * records the cause flags, runs the start-up delay and holds the core while
 * it runs, and exposes cause and interrupt registers over Avalon-MM.
 * Assumes core events arrive as one-cycle pulses on i_clk, and the reset
 * pin arrives asynchronously, active low.
 */
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcsc_cfg.svh"

module rcsc_top #(
    parameter int unsigned STARTUP_CYCLES = `RCSC_STARTUP_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic                      i_clk,
    input  wire logic                      i_reset_n,
    input  wire logic                      i_ce,
    // reset pin, asynchronous
    input  wire logic                      i_ext_reset_pin_n,
    // core and watchdog events
    input  wire rcsc_pkg::rcsc_core_evt_t  i_evt,
    // core control
    output rcsc_pkg::rcsc_core_ctl_t       o_core,
    output rcsc_pkg::rcsc_flags_t          o_flags,
    output rcsc_pkg::rcsc_defaults_t       o_defaults,
    // interrupt
    output logic                           o_irq,
    // Avalon-MM slave
    input  wire logic [`RCSC_ADDR_W-1:0]   i_avs_address,
    input  wire logic                      i_avs_read,
    input  wire logic                      i_avs_write,
    input  wire logic [31:0]               i_avs_writedata,
    output logic [31:0]                    o_avs_readdata,
    output logic                           o_avs_waitrequest
);
    import rcsc_pkg::*;

    typedef struct packed {
        rcsc_state_t              fsm;
        rcsc_flags_t              flags;
        rcsc_core_ctl_t           core;
        rcsc_defaults_t           defaults;
        logic                     pin_s1;
        logic                     pin_s2;
        logic                     pin_s3;
        logic                     pin_asserted;
        logic [`RCSC_IRQ_W-1:0]   irq_status;
        logic [`RCSC_IRQ_W-1:0]   irq_mask;
        logic                     irq;
        logic [31:0]              readdata;
        logic                     waitrequest;
    } rcsc_state_all_t;

    rcsc_state_all_t state;
    rcsc_state_all_t next_state;

    logic tmr_start;
    logic tmr_busy;
    logic tmr_last;

    // control word for the core, chosen by target state
    function automatic rcsc_core_ctl_t core_ctl(input logic chip, input logic stall,
                                                input logic pc_sp, input logic powerup);
        rcsc_core_ctl_t c;
        c.chip_reset     = chip;
        c.stall          = stall;
        c.pc_sp_clear    = chip | pc_sp;
        c.watchdog_clear = chip;
        c.load_defaults  = chip;
        c.powerup        = powerup;
        return c;
    endfunction

    function automatic rcsc_defaults_t reset_defaults();
        rcsc_defaults_t d;
        d.timer_control     = `RCSC_TIMER_CONTROL_RST;
        d.interrupt_control = `RCSC_INT_CONTROL_RST;
        d.converter_control = `RCSC_CONV_CONTROL_RST;
        d.porta_data        = `RCSC_PORTA_RST;
        d.porta_dir         = `RCSC_PORTA_RST;
        d.portb_data        = `RCSC_PORTB_RST;
        d.portb_dir         = `RCSC_PORTB_RST;
        d.portd_data        = `RCSC_PORTD_RST;
        d.portd_dir         = `RCSC_PORTD_RST;
        return d;
    endfunction

    rcsc_startup_timer #(
        .CYCLES    (STARTUP_CYCLES)
    ) u_startup_delay_timer (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_start   (tmr_start),
        .o_busy    (tmr_busy),
        .o_last    (tmr_last)
    );

    always_comb begin
        logic                   bus_req;
        logic                   bus_accept;
        logic [`RCSC_IRQ_W-1:0] evt_set;
        logic [`RCSC_IRQ_W-1:0] w1c;

        next_state = state;
        tmr_start  = 1'b0;
        evt_set    = '0;
        w1c        = '0;
        bus_req    = i_avs_read | i_avs_write;
        bus_accept = bus_req & ~state.waitrequest;

        // pin synchroniser; a change counts once the last two stages agree
        next_state.pin_s1 = i_ext_reset_pin_n;
        next_state.pin_s2 = state.pin_s1;
        next_state.pin_s3 = state.pin_s2;
        if (state.pin_s2 == state.pin_s3) begin
            next_state.pin_asserted = ~state.pin_s3;
        end

        // watchdog-clear instruction
        if (i_evt.watchdog_clear_exec && (state.fsm == RCSC_ST_RUN)) begin
            next_state.flags.powerdown_flag = 1'b0;
        end

        case (state.fsm)
            RCSC_ST_RUN: begin
                next_state.core = core_ctl(1'b0, 1'b0, 1'b0, 1'b0);
                if (state.pin_asserted) begin
                    // flags unchanged for a pin reset in run
                    next_state.fsm  = RCSC_ST_PIN_HOLD;
                    next_state.core = core_ctl(1'b1, 1'b0, 1'b0, 1'b0);
                end else if (i_evt.watchdog_timeout) begin
                    next_state.fsm                = RCSC_ST_RST_DELAY;
                    next_state.flags.timeout_flag = 1'b1;
                    next_state.core = core_ctl(1'b1, 1'b0, 1'b0, 1'b0);
                    tmr_start       = 1'b1;
                end else if (i_evt.halt_exec) begin
                    next_state.fsm                  = RCSC_ST_SLEEP;
                    next_state.flags.powerdown_flag = 1'b1;
                    next_state.flags.timeout_flag   = 1'b0;
                    next_state.core = core_ctl(1'b0, 1'b1, 1'b0, 1'b0);
                end
            end
            RCSC_ST_SLEEP: begin
                if (state.pin_asserted) begin
                    next_state.fsm                  = RCSC_ST_PIN_HOLD;
                    next_state.flags.timeout_flag   = 1'b0;
                    next_state.flags.powerdown_flag = 1'b1;
                    next_state.core = core_ctl(1'b1, 1'b0, 1'b0, 1'b0);
                end else if (i_evt.watchdog_timeout) begin
                    // warm reset: only program counter and stack pointer
                    next_state.fsm                  = RCSC_ST_WAKE_DELAY;
                    next_state.flags.timeout_flag   = 1'b1;
                    next_state.flags.powerdown_flag = 1'b1;
                    next_state.core = core_ctl(1'b0, 1'b1, 1'b1, 1'b0);
                    tmr_start       = 1'b1;
                    evt_set[`RCSC_IRQ_WARM] = 1'b1;
                end else if (i_evt.wake_event) begin
                    next_state.fsm  = RCSC_ST_WAKE_DELAY;
                    next_state.core = core_ctl(1'b0, 1'b1, 1'b0, 1'b0);
                    tmr_start       = 1'b1;
                    evt_set[`RCSC_IRQ_WAKE] = 1'b1;
                end
            end
            RCSC_ST_PIN_HOLD: begin
                next_state.core = core_ctl(1'b1, 1'b0, 1'b0, state.core.powerup);
                if (!state.pin_asserted) begin
                    next_state.fsm = RCSC_ST_RST_DELAY;
                    tmr_start      = 1'b1;
                end
            end
            RCSC_ST_RST_DELAY: begin
                if (state.pin_asserted) begin
                    next_state.fsm = RCSC_ST_PIN_HOLD;
                end else if (tmr_last) begin
                    next_state.fsm  = RCSC_ST_RUN;
                    next_state.core = core_ctl(1'b0, 1'b0, 1'b0, 1'b0);
                    evt_set[`RCSC_IRQ_CHIP_DONE] = 1'b1;
                end
            end
            RCSC_ST_WAKE_DELAY: begin
                next_state.core = core_ctl(1'b0, 1'b1, 1'b0, 1'b0);
                if (state.pin_asserted) begin
                    next_state.fsm  = RCSC_ST_PIN_HOLD;
                    next_state.core = core_ctl(1'b1, 1'b0, 1'b0, 1'b0);
                end else if (tmr_last) begin
                    next_state.fsm  = RCSC_ST_RUN;
                    next_state.core = core_ctl(1'b0, 1'b0, 1'b0, 1'b0);
                end
            end
            default: begin
                next_state.fsm  = RCSC_ST_RUN;
                next_state.core = core_ctl(1'b0, 1'b0, 1'b0, 1'b0);
            end
        endcase

        // reset values on every non-warm reset
        if (next_state.core.load_defaults) begin
            next_state.defaults = reset_defaults();
        end

        // Avalon-MM slave: one wait cycle, then the answer
        next_state.waitrequest = ~(bus_req & state.waitrequest);
        if (i_avs_read && state.waitrequest) begin
            case (i_avs_address)
                `RCSC_OFS_CAUSE: begin
                    next_state.readdata = '0;
                    next_state.readdata[`RCSC_CAUSE_POWERDOWN] = state.flags.powerdown_flag;
                    next_state.readdata[`RCSC_CAUSE_TIMEOUT]   = state.flags.timeout_flag;
                    next_state.readdata[`RCSC_CAUSE_STATE_LO +: 3] = state.fsm;
                    next_state.readdata[`RCSC_CAUSE_POWERUP]   = state.core.powerup;
                end
                `RCSC_OFS_IRQ_STATUS: begin
                    next_state.readdata = {29'h0000_0000, state.irq_status};
                end
                `RCSC_OFS_IRQ_MASK: begin
                    next_state.readdata = {29'h0000_0000, state.irq_mask};
                end
                default: begin
                    next_state.readdata = 32'h0000_0000;
                end
            endcase
        end
        if (bus_accept && i_avs_write) begin
            case (i_avs_address)
                `RCSC_OFS_IRQ_STATUS: w1c = i_avs_writedata[`RCSC_IRQ_W-1:0];
                `RCSC_OFS_IRQ_MASK:   next_state.irq_mask = i_avs_writedata[`RCSC_IRQ_W-1:0];
                default:              w1c = '0;
            endcase
        end

        // set wins over a same-cycle clear
        next_state.irq_status = (state.irq_status & ~w1c) | evt_set;
        next_state.irq        = |(next_state.irq_status & next_state.irq_mask);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            // power-up: flags 0,0 and a start-up delay inside the reset
            state.fsm          <= RCSC_ST_RST_DELAY;
            state.flags        <= '0;
            state.core         <= core_ctl(1'b1, 1'b0, 1'b0, 1'b1);
            state.defaults     <= reset_defaults();
            state.pin_s1       <= 1'b1;
            state.pin_s2       <= 1'b1;
            state.pin_s3       <= 1'b1;
            state.pin_asserted <= 1'b0;
            state.irq_status   <= '0;
            state.irq_mask     <= `RCSC_IRQ_MASK_RST;
            state.irq          <= 1'b0;
            state.readdata     <= 32'h0000_0000;
            state.waitrequest  <= 1'b1;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    assign o_core            = state.core;
    assign o_flags           = state.flags;
    assign o_defaults        = state.defaults;
    assign o_irq             = state.irq;
    assign o_avs_readdata    = state.readdata;
    assign o_avs_waitrequest = state.waitrequest;

endmodule

`default_nettype wire

/* File: tb/rcsc_chk.sv */
/*
 * Checker of the reset cause and start-up control block: flags, holds, delays.
 * Assumes binding into rcsc_top; no core events while i_ce is low.
 */
`timescale 1ns/1ps
`default_nettype none

module rcsc_chk #(
    parameter int unsigned STARTUP_CYCLES = 1024
) (
    // clock and reset
    input wire logic                     i_clk,
    input wire logic                     i_reset_n,
    input wire logic                     i_ce,
    // watched ports
    input wire logic                     i_ext_reset_pin_n,
    input wire rcsc_pkg::rcsc_core_evt_t i_evt,
    input wire rcsc_pkg::rcsc_core_ctl_t o_core,
    input wire rcsc_pkg::rcsc_flags_t    o_flags,
    input wire rcsc_pkg::rcsc_defaults_t o_defaults
);
    import rcsc_pkg::*;
    localparam logic [49:0] DEF = {8'h08, 8'h00, 8'h40, 8'hff, 8'hff, 4'hf, 4'hf, 1'h1, 1'h1};
    logic [2:0]  pin_hi;
    logic        asleep;
    logic        clean;
    logic [11:0] cnt;
    logic        pin_ok;
    logic        busy;
    logic        run;
    logic        start;

    assign pin_ok = pin_hi == 3'h7;
    assign busy   = o_core.chip_reset || o_core.stall;
    assign run    = !busy && pin_ok;
    assign start  = (run && i_evt.watchdog_timeout)
                  || (asleep && pin_ok && (i_evt.watchdog_timeout || i_evt.wake_event));

    // cnt: cycles held since the last start; clean: no pin reset meanwhile
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pin_hi <= i_ext_reset_pin_n ? 3'h7 : 3'h0;
            asleep <= 1'b0;
            clean  <= 1'b1;
            cnt    <= 12'h0;
        end else if (i_ce) begin
            pin_hi <= !i_ext_reset_pin_n ? 3'h0 : (pin_ok ? pin_hi : pin_hi + 3'h1);
            asleep <= (run && i_evt.halt_exec && !i_evt.watchdog_timeout)
                    || (asleep && pin_ok && !start && !o_core.chip_reset);
            clean  <= start || (clean && pin_ok);
            cnt    <= start ? 12'h0 : (busy ? cnt + 12'h1 : 12'h0);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sleep_entry_a: assert property (
        run && i_evt.halt_exec && !i_evt.watchdog_timeout
        |=> o_flags == 2'h1 && o_core.stall && !o_core.chip_reset)
        else $error("sleep entry flags or stall wrong");
    run_timeout_a: assert property (
        run && i_evt.watchdog_timeout |=> o_core.chip_reset && o_flags.timeout_flag
        && o_flags.powerdown_flag == $past(o_flags.powerdown_flag))
        else $error("run time-out did not reset");
    warm_reset_a: assert property (
        asleep && pin_ok && i_evt.watchdog_timeout |=> o_flags == 2'h3 && o_core.pc_sp_clear
        && o_core.stall && !o_core.load_defaults ##1 !o_core.pc_sp_clear)
        else $error("warm reset wrong");
    wake_keep_a: assert property (
        asleep && pin_ok && i_evt.wake_event && !i_evt.watchdog_timeout
        |=> $stable(o_flags) && o_core.stall && !o_core.chip_reset)
        else $error("wake changed flags or reset");
    delay_len_a: assert property (
        !busy && cnt != 12'h0 && clean |-> cnt == STARTUP_CYCLES[11:0])
        else $error("start-up delay length wrong");
    chip_values_a: assert property (
        o_core.chip_reset |-> o_core.load_defaults && o_core.pc_sp_clear
        && o_core.watchdog_clear && o_defaults == DEF)
        else $error("chip reset controls wrong");
    wd_clear_a: assert property (
        run && i_evt.watchdog_clear_exec && !i_evt.watchdog_timeout && !i_evt.halt_exec
        |=> !o_flags.powerdown_flag && o_flags.timeout_flag == $past(o_flags.timeout_flag))
        else $error("watchdog clear did not drop powerdown");
    powerup_flags_a: assert property (
        o_core.powerup |-> o_core.chip_reset && o_flags == 2'h0)
        else $error("power-up flags wrong");
    pin_sleep_a: assert property (
        $fell(i_ext_reset_pin_n) && asleep |-> ##[1:5] (o_core.chip_reset && o_flags == 2'h1))
        else $error("pin wake reset wrong");
    pin_run_a: assert property (
        $fell(i_ext_reset_pin_n) && run |-> ##[1:5] o_core.chip_reset)
        else $error("pin reset not taken");

    cover property (run && i_evt.halt_exec);
    cover property (asleep && pin_ok && i_evt.watchdog_timeout);
    cover property (!busy && cnt != 12'h0 && clean);
endmodule

bind rcsc_top rcsc_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) rcsc_chk_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_ext_reset_pin_n(i_ext_reset_pin_n),
    .i_evt(i_evt), .o_core(o_core), .o_flags(o_flags), .o_defaults(o_defaults));

`default_nettype wire

/* File: tb/rcsc_core_model.sv */
/*
 * Core and reset pin model: pulses core events, drives the pin, keeps a
 * timer control copy that loads from the offered defaults.
 * Assumes the bench calls its tasks.
 */
`timescale 1ns/1ps
`default_nettype none

module rcsc_core_model (
    // clock
    input  wire logic                     i_clk,
    // from the block
    input  wire rcsc_pkg::rcsc_core_ctl_t i_core,
    input  wire rcsc_pkg::rcsc_defaults_t i_defaults,
    // to the block, and the timer control copy to the bench
    output rcsc_pkg::rcsc_core_evt_t      o_evt,
    output logic                          o_pin_n,
    output logic [7:0]                    o_timer_control
);
    import rcsc_pkg::*;
    initial begin
        o_evt = '0;
        o_pin_n = 1'b1;
        o_timer_control = 8'h00;
    end
    always @(posedge i_clk) if (i_core.load_defaults) o_timer_control <= i_defaults.timer_control;
    // software changes the timer control
    task automatic scribble;
        @(posedge i_clk);
        o_timer_control <= 8'h55;
    endtask
    // one-cycle event pulse; b is the event's bit
    task automatic fire(input int b);
        @(posedge i_clk);
        o_evt[b] <= 1'b1;
        @(posedge i_clk);
        o_evt <= '0;
    endtask
    task automatic pin(input int len);
        @(posedge i_clk);
        o_pin_n <= 1'b0;
        repeat (len) @(posedge i_clk);
        o_pin_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: tb/rcsc_tb_top.sv */
/*
 * Bench of rcsc_top: events in run and sleep, pin resets, delays, registers.
 * Assumes the checker and the core model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module rcsc_tb_top;
    import rcsc_pkg::*;
    localparam int unsigned SC = 8;
    localparam logic [49:0] DEF = {8'h08, 8'h00, 8'h40, 8'hff, 8'hff, 4'hf, 4'hf, 1'h1, 1'h1};
    typedef struct packed {
        logic       sl;
        logic [2:0] ev;
        logic [1:0] fl;
        logic       ch;
    } rcsc_row_t;
    logic           i_clk;
    logic           i_reset_n;
    logic [3:0]     i_avs_address;
    logic           i_avs_read;
    logic           i_avs_write;
    logic [31:0]    i_avs_writedata;
    logic [31:0]    o_avs_readdata;
    logic           o_avs_waitrequest;
    logic           o_irq;
    logic           pin_n;
    logic           ce;
    logic [7:0]     tc;
    logic [31:0]    q;
    rcsc_core_evt_t evt;
    rcsc_core_ctl_t o_core;
    rcsc_flags_t    o_flags;
    rcsc_defaults_t o_defaults;
    int             n_mismatch;
    int             num_checks;
    int             n;
    // sleep first, event (0 time-out, 1 wake, 2 watchdog clear, 4 pin), flags, chip reset
    rcsc_row_t      rows [7] = '{'{0, 0, 2, 1}, '{1, 1, 1, 0}, '{1, 0, 3, 0}, '{0, 2, 2, 0},
                                 '{1, 4, 1, 1}, '{0, 4, 1, 1}, '{0, 0, 3, 1}};

    rcsc_top #(.STARTUP_CYCLES(SC)) rcsc_top_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(ce), .i_ext_reset_pin_n(pin_n),
        .i_evt(evt), .o_core(o_core), .o_flags(o_flags), .o_defaults(o_defaults),
        .o_irq(o_irq), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
    rcsc_core_model rcsc_core_model_i (
        .i_clk(i_clk), .i_core(o_core), .i_defaults(o_defaults), .o_evt(evt),
        .o_pin_n(pin_n), .o_timer_control(tc));

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // cycles until the core is let go
    task automatic hold_len(output int len);
        len = 0;
        while ((o_core.chip_reset || o_core.stall) && len < 40) begin
            @(posedge i_clk);
            #1;
            len++;
        end
        if (len >= 40) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int j;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        j = 0;
        do begin
            @(posedge i_clk);
            j++;
        end while (o_avs_waitrequest !== 1'b0 && j < 20);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (j >= 20) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial begin
        n_mismatch = 0;
        num_checks = 0;
        i_reset_n = 1'b0;
        ce = 1'b1;
        i_avs_address = 4'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        chk(o_core.powerup, 1);
        chk(o_defaults, DEF);
        hold_len(n);
        chk(n, SC);
        chk(tc, 8'h08);
        for (int k = 0; k < 7; k++) begin
            rcsc_core_model_i.scribble();
            if (rows[k].sl) begin
                rcsc_core_model_i.fire(3);
                #1;
                chk(o_flags, 2'h1);
            end
            if (rows[k].ev == 3'h4) rcsc_core_model_i.pin(6);
            else rcsc_core_model_i.fire(rows[k].ev);
            #1;
            chk(o_flags, rows[k].fl);
            chk(o_core.chip_reset, rows[k].ch);
            hold_len(n);
            if (rows[k].ev != 3'h4) chk(n, rows[k].ev == 3'h2 ? 0 : SC);
            chk(tc, rows[k].ch ? 8'h08 : 8'h55);
            repeat (2) @(posedge i_clk);
        end
        // time-out during the wake delay is ignored
        rcsc_core_model_i.fire(3);
        rcsc_core_model_i.fire(1);
        rcsc_core_model_i.fire(0);
        #1;
        chk(o_flags, 2'h1);
        hold_len(n);
        chk(n, SC - 2);
        bus(0, 4'h4, 32'h0, q);
        chk(q, 32'h7);
        chk(o_irq, 0);
        bus(1, 4'h8, 32'h2, q);
        repeat (2) @(posedge i_clk);
        #1;
        chk(o_irq, 1);
        bus(1, 4'h4, 32'h2, q);
        repeat (2) @(posedge i_clk);
        #1;
        chk(o_irq, 0);
        bus(0, 4'h4, 32'h0, q);
        chk(q, 32'h5);
        bus(0, 4'h8, 32'h0, q);
        chk(q, 32'h2);
        bus(0, 4'hc, 32'h0, q);
        chk(q, 32'h0);
        bus(1, 4'h0, 32'hff, q);
        bus(0, 4'h0, 32'h0, q);
        chk(q, 32'h1);
        // power-up reset in the middle of a delay
        rcsc_core_model_i.fire(0);
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        chk(o_flags, 2'h0);
        chk(o_core.powerup, 1);
        // clock enable low for three edges freezes the delay
        @(posedge i_clk);
        ce <= 1'b0;
        repeat (3) @(posedge i_clk);
        ce <= 1'b1;
        hold_len(n);
        chk(n, SC - 1);
        report_and_stop();
    end
endmodule

`default_nettype wire
